// file: rsim_pkg.sv
package rsim_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [6:0] RSIM_SEC_STATUS_ADDR = 7'h08;
	localparam logic [6:0] RSIM_MODE_HIGH_ADDR = 7'h0d;
	localparam logic [6:0] RSIM_MODE_LOW_ADDR = 7'h0e;
	localparam logic [6:0] RSIM_CHAN_SUMMARY_ADDR = 7'h0f;
	localparam logic [6:0] RSIM_RX_ERROR_ADDR = 7'h10;
	// ************************************************************
	// Fields, reset values and codes
	// ************************************************************
	localparam int RSIM_SRC_N = 6;
	localparam int RSIM_ERR_N = 7;
	localparam int RSIM_QSUB_ERR_BIT = 6;
	localparam logic [5:0] RSIM_MODE_RESET = 6'h00;
	localparam logic [3:0] RSIM_AUX_MAX = 4'h8;
	typedef enum logic [1:0] {
		RSIM_TRIG_RISE = 2'h0,
		RSIM_TRIG_FALL = 2'h1,
		RSIM_TRIG_LEVEL = 2'h2,
		RSIM_TRIG_RSVD = 2'h3
	} rsim_trig_t;
endpackage

// file: rsim_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Trigger code split high 0Dh, low 0Eh
// R02 - Six sources bits 5..0, code 11 reserved
// R03 - Code 00 fires on condition arrival
// R04 - Code 01 fires on condition removal
// R05 - Code 10 holds interrupt while condition persists
// R06 - Software programs both mode registers per source
// R07 - Mode registers reset to zero
// R08 - Read-only channel summary byte at 0Fh
// R09 - Read-only error byte at 10h, bit7 zero
// R10 - Q-subcode check error set at block boundaries
// R11 - Status read clears except persisting level sources
// R12 - Masked source affects neither interrupt nor status
// R13 - Channel pick selects channel A or B
// R14 - Auxiliary length coded 0000 to 1000
// R15 - Error flags latch, read clears except still-present errors, masked read zero
module rsim_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [rsim_pkg::RSIM_SRC_N-1:0] sec_cond,
	input wire logic [rsim_pkg::RSIM_SRC_N-1:0] sec_irq_mask,
	output logic sec_irq,
	input wire logic channel_pick,
	input wire logic [3:0] aux_len_a,
	input wire logic [3:0] flags_a,
	input wire logic [3:0] aux_len_b,
	input wire logic [3:0] flags_b,
	input wire logic qsub_boundary,
	input wire logic qsub_crc_fail,
	input wire logic [rsim_pkg::RSIM_ERR_N-2:0] rx_err_cond,
	input wire logic [rsim_pkg::RSIM_ERR_N-1:0] rx_err_mask
);
	import rsim_pkg::*;

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (RSIM_SRC_N != 6 || RSIM_ERR_N != 7) begin : g_width_check
		$error("source and error counts must fit the byte registers");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [5:0] mode_high;
		logic [5:0] mode_low;
		logic [5:0] sec_status;
		logic [5:0] cond_prev;
		logic [6:0] err_flags;
		logic qsub_err_now;
		logic [7:0] rdata;
	} rsim_state_t;

	rsim_state_t state_q;
	rsim_state_t state_d;
	logic [5:0] sec_event;
	logic [5:0] sec_keep;
	logic [6:0] err_new;
	logic [6:0] err_present;
	logic [7:0] summary;
	logic rd_status;
	logic rd_error;

	// R14 aux length clamp
	function automatic logic [3:0] rsim_aux_code(input logic [3:0] len);
		rsim_aux_code = (len > RSIM_AUX_MAX) ? RSIM_AUX_MAX : len;
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		state_d = state_q;
		rd_status = reg_rd && (reg_addr == RSIM_SEC_STATUS_ADDR);
		rd_error = reg_rd && (reg_addr == RSIM_RX_ERROR_ADDR);
		// R13 channel pick
		summary = channel_pick ? {rsim_aux_code(aux_len_b), flags_b} :
			{rsim_aux_code(aux_len_a), flags_a};
		for (int i = 0; i < RSIM_SRC_N; i++) begin
			rsim_trig_t code;
			code = rsim_trig_t'({state_q.mode_high[i], state_q.mode_low[i]});
			sec_event[i] = 1'b0;
			sec_keep[i] = 1'b0;
			unique case (code)
				// R03 arrival edge
				RSIM_TRIG_RISE: sec_event[i] = sec_cond[i] && !state_q.cond_prev[i];
				// R04 removal edge
				RSIM_TRIG_FALL: sec_event[i] = !sec_cond[i] && state_q.cond_prev[i];
				// R05 level persistence
				RSIM_TRIG_LEVEL: begin
					sec_event[i] = sec_cond[i];
					sec_keep[i] = sec_cond[i];
				end
				RSIM_TRIG_RSVD: sec_event[i] = 1'b0;
			endcase
		end
		state_d.cond_prev = sec_cond;
		// R11 read clear, set wins; R12 mask gating
		state_d.sec_status = ((rd_status ? sec_keep : state_q.sec_status) | sec_event)
			& sec_irq_mask;
		// R10 Q-subcode check at block boundary
		if (qsub_boundary) begin
			state_d.qsub_err_now = qsub_crc_fail;
		end
		err_new = {qsub_boundary && qsub_crc_fail, rx_err_cond};
		err_present = {state_d.qsub_err_now, rx_err_cond};
		// R15 latch, read clear, mask
		state_d.err_flags = ((rd_error ? err_present : state_q.err_flags) | err_new)
			& rx_err_mask;
		// R01 split mode registers, R02 upper bits zero
		if (reg_wr && reg_addr == RSIM_MODE_HIGH_ADDR) begin
			state_d.mode_high = reg_wdata[5:0];
		end
		if (reg_wr && reg_addr == RSIM_MODE_LOW_ADDR) begin
			state_d.mode_low = reg_wdata[5:0];
		end
		if (reg_rd) begin
			unique case (reg_addr)
				RSIM_SEC_STATUS_ADDR: state_d.rdata = {2'h0, state_q.sec_status};
				RSIM_MODE_HIGH_ADDR: state_d.rdata = {2'h0, state_q.mode_high};
				RSIM_MODE_LOW_ADDR: state_d.rdata = {2'h0, state_q.mode_low};
				// R08 summary byte
				RSIM_CHAN_SUMMARY_ADDR: state_d.rdata = summary;
				// R09 error byte
				RSIM_RX_ERROR_ADDR: state_d.rdata = {1'b0, state_q.err_flags};
				default: state_d.rdata = 8'h00;
			endcase
		end
		if (!rst_n) begin
			// R07 mode reset
			state_d = '0;
			state_d.mode_high = RSIM_MODE_RESET;
			state_d.mode_low = RSIM_MODE_RESET;
		end
	end

	always_ff @(posedge clk) begin
		state_q <= state_d;
	end

	assign reg_rdata = state_q.rdata;
	assign sec_irq = |state_q.sec_status;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_rise0;
		sec_irq_mask[0] && !state_q.mode_high[0] && !state_q.mode_low[0]
			&& sec_cond[0] && !state_q.cond_prev[0];
	endsequence
	sequence s_fall1;
		sec_irq_mask[1] && !state_q.mode_high[1] && state_q.mode_low[1]
			&& !sec_cond[1] && state_q.cond_prev[1];
	endsequence
	sequence s_level2;
		sec_irq_mask[2] && state_q.mode_high[2] && !state_q.mode_low[2] && sec_cond[2];
	endsequence
	sequence s_level2_read;
		sec_irq_mask[2] && state_q.mode_high[2] && !state_q.mode_low[2] && sec_cond[2]
			&& rd_status;
	endsequence

	mode_reset_a: assert property (@(posedge clk) !rst_n |=> // R07
		state_q.mode_high == 6'h00 && state_q.mode_low == 6'h00)
		else $error("mode registers not zero after reset");
	mode_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R01
		reg_wr && reg_addr == RSIM_MODE_LOW_ADDR |=> state_q.mode_low == $past(reg_wdata[5:0]))
		else $error("low mode register write lost");
	rise_event_a: assert property (@(posedge clk) disable iff (!rst_n) // R03
		s_rise0 |=> state_q.sec_status[0] && sec_irq)
		else $error("rising edge did not raise interrupt");
	fall_event_a: assert property (@(posedge clk) disable iff (!rst_n) // R04
		s_fall1 |=> state_q.sec_status[1] && sec_irq)
		else $error("falling edge did not raise interrupt");
	level_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R05
		s_level2 ##1 s_level2_read |=> state_q.sec_status[2] && sec_irq)
		else $error("level source released interrupt");
	masked_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		!$past(sec_irq_mask[4]) |-> !state_q.sec_status[4])
		else $error("masked source reached status");
	read_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
		rd_status && sec_cond == 6'h00 && state_q.cond_prev == 6'h00
		|=> state_q.sec_status == 6'h00)
		else $error("status read did not clear");
	qsub_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		qsub_boundary && qsub_crc_fail && rx_err_mask[6] |=> state_q.err_flags[6])
		else $error("Q-subcode error not latched");
	err_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
		state_q.err_flags[0] && !rd_error && rx_err_mask[0] |=> state_q.err_flags[0])
		else $error("error flag dropped without read");
	chan_pick_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		reg_rd && reg_addr == RSIM_CHAN_SUMMARY_ADDR && channel_pick
		|=> reg_rdata[3:0] == $past(flags_b))
		else $error("channel B summary not returned");
	err_top_a: assert property (@(posedge clk) disable iff (!rst_n) // R09
		rd_error |=> !reg_rdata[7])
		else $error("error byte bit 7 not zero");
	high_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R01
		reg_wr && reg_addr == RSIM_MODE_HIGH_ADDR |=> state_q.mode_high == $past(reg_wdata[5:0]))
		else $error("high mode register write lost");
	rsvd_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // R02
		state_q.mode_high[3] && state_q.mode_low[3] && !state_q.sec_status[3]
		|=> !state_q.sec_status[3])
		else $error("reserved trigger code raised status");
	chan_a_flags_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		reg_rd && reg_addr == RSIM_CHAN_SUMMARY_ADDR && !channel_pick
		|=> reg_rdata[3:0] == $past(flags_a))
		else $error("channel A summary not returned");
	aux_clamp_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		reg_rd && reg_addr == RSIM_CHAN_SUMMARY_ADDR |=> reg_rdata[7:4] <= RSIM_AUX_MAX)
		else $error("auxiliary length code above eight");
	err_masked_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
		!$past(rx_err_mask[0]) |-> !state_q.err_flags[0])
		else $error("masked error reached flags");
	qsub_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		!qsub_boundary && !rd_error && !state_q.err_flags[RSIM_QSUB_ERR_BIT]
		|=> !state_q.err_flags[RSIM_QSUB_ERR_BIT])
		else $error("Q-subcode error set between boundaries");
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import rsim_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [5:0] sec_cond = 6'h00;
	logic [5:0] sec_irq_mask = 6'h3f;
	logic sec_irq;
	logic channel_pick = 1'b0;
	logic [3:0] aux_len_a = 4'h0;
	logic [3:0] flags_a = 4'h0;
	logic [3:0] aux_len_b = 4'h0;
	logic [3:0] flags_b = 4'h0;
	logic qsub_boundary = 1'b0;
	logic qsub_crc_fail = 1'b0;
	logic [5:0] rx_err_cond = 6'h00;
	logic [6:0] rx_err_mask = 7'h7f;
	int errors = 0;
	int compares = 0;
	rsim_regs rsim_regs_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sec_cond(sec_cond),
		.sec_irq_mask(sec_irq_mask), .sec_irq(sec_irq), .channel_pick(channel_pick),
		.aux_len_a(aux_len_a), .flags_a(flags_a), .aux_len_b(aux_len_b), .flags_b(flags_b),
		.qsub_boundary(qsub_boundary), .qsub_crc_fail(qsub_crc_fail),
		.rx_err_cond(rx_err_cond), .rx_err_mask(rx_err_mask));
	// ************************************************************
	// Bus cycles and checks
	// ************************************************************
	task automatic print_verdict;
		if (errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [6:0] a, input logic [7:0] e, input string n);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(n, reg_rdata, e);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_modes;
		rc(RSIM_MODE_HIGH_ADDR, 8'h00, "mode_high");
		rc(RSIM_MODE_LOW_ADDR, 8'h00, "mode_low");
		rc(7'h7f, 8'h00, "unmapped");
		wr(RSIM_MODE_HIGH_ADDR, 8'hff);
		rc(RSIM_MODE_HIGH_ADDR, 8'h3f, "mode_high");
		wr(RSIM_MODE_LOW_ADDR, 8'hc5);
		rc(RSIM_MODE_LOW_ADDR, 8'h05, "mode_low");
	endtask
	task automatic t_events;
		wr(RSIM_MODE_HIGH_ADDR, 8'h0c);
		wr(RSIM_MODE_LOW_ADDR, 8'h0a);
		sec_irq_mask <= 6'h2f;
		cyc(2);
		sec_cond <= 6'h1f;
		cyc(3);
		#1 chk("sec_irq", {7'h00, sec_irq}, 8'h01);
		rc(RSIM_SEC_STATUS_ADDR, 8'h05, "status");
		rc(RSIM_SEC_STATUS_ADDR, 8'h04, "status");
		sec_cond <= 6'h00;
		cyc(3);
		rc(RSIM_SEC_STATUS_ADDR, 8'h06, "status");
		rc(RSIM_SEC_STATUS_ADDR, 8'h00, "status");
		cyc(2);
		#1 chk("sec_irq", {7'h00, sec_irq}, 8'h00);
	endtask
	task automatic t_summary;
		aux_len_a <= 4'h8;
		flags_a <= 4'ha;
		aux_len_b <= 4'h3;
		flags_b <= 4'h5;
		cyc(2);
		rc(RSIM_CHAN_SUMMARY_ADDR, 8'h8a, "summary");
		channel_pick <= 1'b1;
		wr(RSIM_CHAN_SUMMARY_ADDR, 8'hff);
		rc(RSIM_CHAN_SUMMARY_ADDR, 8'h35, "summary");
		aux_len_b <= 4'hb;
		cyc(1);
		rc(RSIM_CHAN_SUMMARY_ADDR, 8'h85, "summary");
	endtask
	task automatic t_errors;
		rx_err_cond <= 6'h21;
		cyc(1);
		rx_err_cond <= 6'h00;
		cyc(2);
		rc(RSIM_RX_ERROR_ADDR, 8'h21, "rx_error");
		rc(RSIM_RX_ERROR_ADDR, 8'h00, "rx_error");
		rx_err_mask <= 7'h7e;
		rx_err_cond <= 6'h03;
		qsub_crc_fail <= 1'b1;
		cyc(3);
		rc(RSIM_RX_ERROR_ADDR, 8'h02, "rx_error");
		rc(RSIM_RX_ERROR_ADDR, 8'h02, "rx_error");
		qsub_boundary <= 1'b1;
		rx_err_cond <= 6'h00;
		cyc(1);
		qsub_boundary <= 1'b0;
		cyc(2);
		rc(RSIM_RX_ERROR_ADDR, 8'h42, "rx_error");
	endtask
	task automatic t_reset;
		sec_cond <= 6'h01;
		cyc(2);
		#1 chk("sec_irq", {7'h00, sec_irq}, 8'h01);
		rst_n <= 1'b0;
		sec_cond <= 6'h00;
		cyc(2);
		rst_n <= 1'b1;
		rc(RSIM_MODE_HIGH_ADDR, 8'h00, "mode_high");
		rc(RSIM_RX_ERROR_ADDR, 8'h00, "rx_error");
		chk("sec_irq", {7'h00, sec_irq}, 8'h00);
	endtask
	initial forever #50 clk = ~clk;
	initial begin
		#(100 * 5000);
		errors++;
		print_verdict();
	end
	initial begin
		cyc(20);
		rst_n <= 1'b1;
		t_modes();
		t_events();
		t_summary();
		t_errors();
		t_reset();
		print_verdict();
	end
endmodule
